// [core/cbrs_core.sv]
/*
  Architectural register state of a 4-bit core: banked working registers,
  status word, bank selectors and stack pointer.
  Assumes a decoder/sequencer drives one operation per cycle, and that the
  memory-mapped port is the data memory path of the core.
*/
`timescale 1ns/10ps
`include "cbrs_defs.svh"
module cbrs_core
  import cbrs_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int REGS = 8
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  // vector byte fetched at reset or interrupt entry
  input wire logic [7:0] vector_byte,
  input wire logic vector_load,
  // working register ports
  input wire logic reg_wr,
  input wire logic [2:0] reg_idx,
  input wire logic [3:0] reg_wdata,
  input wire logic pair_wr,
  input wire logic [1:0] pair_idx,
  input wire logic pair_alt,
  input wire logic [7:0] pair_wdata,
  // data memory port
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [11:0] mem_addr,
  input wire logic [3:0] mem_wdata,
  input wire logic mem_wide,
  input wire logic [7:0] mem_wdata8,
  // carry, skip, enable flag and bank selector control
  input wire cbrs_cy_op_t cy_op,
  input wire logic cy_in,
  input wire logic [2:0] skip_in,
  input wire logic skip_wr,
  input wire logic mbe_bit_wr,
  input wire logic rbe_bit_wr,
  input wire logic flag_val,
  input wire logic [3:0] sel_mbs,
  input wire logic sel_mbs_wr,
  input wire logic [1:0] sel_rbs,
  input wire logic sel_rbs_wr,
  // stack
  input wire cbrs_stack_op_t stack_op,
  input wire logic [7:0] stack_rdata,
  input wire logic int_disabled,
  // outputs
  output logic [3:0] mem_rdata,
  output logic [7:0] mem_rdata8,
  output logic [3:0] reg_rdata,
  output logic [7:0] pair_rdata,
  output logic [3:0] acc_a,
  output logic [7:0] acc_xa,
  output logic carry_bit,
  output logic [7:0] processor_status_word,
  output logic [1:0] active_working_bank,
  output logic [3:0] data_bank,
  output logic [7:0] stack_top_pointer,
  output logic [7:0] stack_push_addr,
  output logic [7:0] stack_wdata,
  output logic stack_wr,
  output logic extended_instruction_mode
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  initial
  begin
    if (BANKS != 4 || REGS != 8)
      $error("cbrs_core: register file geometry must be 4 banks of 8");
  end

  typedef struct packed {
    logic [BANKS*REGS-1:0][3:0] regs;
    logic [7:0] sp;
    logic [3:0] stack_bank_select;
    logic [3:0] memory_bank_select;
    logic [1:0] register_bank_select;
    logic cy;
    logic [2:0] sk;
    logic [1:0] ist;
    logic data_bank_enable_flag;
    logic working_bank_enable_flag;
    logic [3:0] mem_rdata;
    logic [7:0] mem_rdata8;
    logic [3:0] reg_rdata;
    logic [7:0] pair_rdata;
    logic [7:0] push_addr;
    logic [7:0] push_data;
    logic push_wr;
  } cbrs_state_t;

  cbrs_state_t st;
  cbrs_state_t next_st;

  // active bank: enable ANDed with selector
  function automatic logic [1:0] bank_of(input logic working_bank_enable_flag, input logic [1:0] register_bank_select);
    bank_of = working_bank_enable_flag ? register_bank_select : 2'h0;
  endfunction

  // flat index of a register of a bank
  function automatic logic [4:0] flat(input logic [1:0] bank, input logic [2:0] idx);
    flat = {bank, idx};
  endfunction

  function automatic logic [7:0] psw_of(input cbrs_state_t s);
    psw_of = {s.cy, s.sk, s.ist, s.data_bank_enable_flag, s.working_bank_enable_flag};
  endfunction

  logic [1:0] cur_bank;
  logic [1:0] pair_bank;
  logic [4:0] pair_lo;
  logic reg_area;
  assign cur_bank = bank_of(st.working_bank_enable_flag, st.register_bank_select);
  assign pair_bank = cur_bank ^ {1'b0, pair_alt};
  // pair order X/A=0, H/L=1, D/E=2, B/C=3; low nibble at even index
  assign pair_lo = flat(pair_bank, {pair_idx, 1'b0});
  // register area lives in bank 0 of data memory at 000-01F
  assign reg_area = (mem_addr <= `CBRS_REG_TOP_ADDR);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.push_wr = 1'b0;
    next_st.reg_rdata = st.regs[flat(cur_bank, reg_idx)];
    next_st.pair_rdata = {st.regs[pair_lo + 5'h1], st.regs[pair_lo]};
    if (reg_wr)
      next_st.regs[flat(cur_bank, reg_idx)] = reg_wdata;
    if (pair_wr)
    begin
      next_st.regs[pair_lo] = pair_wdata[3:0];
      next_st.regs[pair_lo + 5'h1] = pair_wdata[7:4];
    end
    // memory mapped view
    next_st.mem_rdata = 4'h0;
    next_st.mem_rdata8 = 8'h00;
    if (mem_rd)
    begin
      if (reg_area)
      begin
        next_st.mem_rdata = st.regs[mem_addr[4:0]];
        next_st.mem_rdata8 = {st.regs[{mem_addr[4:1], 1'b1}], st.regs[{mem_addr[4:1], 1'b0}]};
      end
      else
      begin
        case (mem_addr)
          `CBRS_PSW_LO_ADDR: next_st.mem_rdata = {st.ist, st.data_bank_enable_flag, st.working_bank_enable_flag};
          `CBRS_PSW_HI_ADDR: next_st.mem_rdata = {st.cy, st.sk};
          `CBRS_SP_ADDR: next_st.mem_rdata8 = st.sp;
          `CBRS_SBS_ADDR: next_st.mem_rdata = st.stack_bank_select;
          `CBRS_BS_ADDR: next_st.mem_rdata8 = {st.memory_bank_select, 2'b00, st.register_bank_select};
          default: next_st.mem_rdata = 4'h0;
        endcase
      end
    end
    if (mem_wr)
    begin
      if (reg_area)
      begin
        if (mem_wide)
        begin
          next_st.regs[{mem_addr[4:1], 1'b0}] = mem_wdata8[3:0];
          next_st.regs[{mem_addr[4:1], 1'b1}] = mem_wdata8[7:4];
        end
        else
          next_st.regs[mem_addr[4:0]] = mem_wdata;
      end
      else
      begin
        case (mem_addr)
          `CBRS_PSW_LO_ADDR:
          begin
            // interrupt status writes only take with interrupts off
            if (int_disabled)
              next_st.ist = mem_wdata[3:2];
            next_st.data_bank_enable_flag = mem_wdata[1];
            next_st.working_bank_enable_flag = mem_wdata[0];
          end
          `CBRS_SP_ADDR:
          begin
            if (mem_wide)
              next_st.sp = mem_wdata8;
          end
          `CBRS_SBS_ADDR: next_st.stack_bank_select = mem_wdata;
          default: next_st.sp = next_st.sp;
        endcase
      end
    end
    // carry as bit accumulator
    case (cy_op)
      CBRS_OP_SET: next_st.cy = 1'b1;
      CBRS_OP_CLR: next_st.cy = 1'b0;
      CBRS_OP_NOT: next_st.cy = ~st.cy;
      CBRS_OP_LOAD: next_st.cy = cy_in;
      CBRS_OP_AND: next_st.cy = st.cy & cy_in;
      CBRS_OP_OR: next_st.cy = st.cy | cy_in;
      CBRS_OP_XOR: next_st.cy = st.cy ^ cy_in;
      CBRS_OP_ARITH: next_st.cy = cy_in;
      default: next_st.cy = next_st.cy;
    endcase
    if (skip_wr)
      next_st.sk = skip_in;
    if (mbe_bit_wr)
      next_st.data_bank_enable_flag = flag_val;
    if (rbe_bit_wr)
      next_st.working_bank_enable_flag = flag_val;
    if (sel_mbs_wr)
      next_st.memory_bank_select = sel_mbs;
    if (sel_rbs_wr)
      next_st.register_bank_select = sel_rbs;
    // stack: predecrement on save, postincrement on restore
    case (stack_op)
      CBRS_ST_CALL, CBRS_ST_INTR, CBRS_ST_PUSHBS:
      begin
        next_st.sp = st.sp - 8'h01;
        next_st.push_addr = st.sp - 8'h01;
        next_st.push_wr = 1'b1;
        if (stack_op == CBRS_ST_CALL)
          next_st.push_data = {6'h00, st.data_bank_enable_flag, st.working_bank_enable_flag};
        else if (stack_op == CBRS_ST_INTR)
        begin
          next_st.push_data = psw_of(st);
          next_st.ist = st.ist + 2'h1;
        end
        else
          next_st.push_data = {st.memory_bank_select, 2'b00, st.register_bank_select};
      end
      CBRS_ST_RET:
      begin
        next_st.data_bank_enable_flag = stack_rdata[`CBRS_PSW_MBE];
        next_st.working_bank_enable_flag = stack_rdata[`CBRS_PSW_RBE];
        next_st.sp = st.sp + 8'h01;
      end
      CBRS_ST_RETURN_FROM_INTERRUPT:
      begin
        {next_st.cy, next_st.sk, next_st.ist, next_st.data_bank_enable_flag, next_st.working_bank_enable_flag} = stack_rdata;
        next_st.sp = st.sp + 8'h01;
      end
      CBRS_ST_POPBS:
      begin
        next_st.memory_bank_select = stack_rdata[7:4];
        next_st.register_bank_select = stack_rdata[1:0];
        next_st.sp = st.sp + 8'h01;
      end
      default: next_st.sp = next_st.sp;
    endcase
    // vector entry loads both enables, after the interrupt save above
    if (vector_load)
    begin
      next_st.data_bank_enable_flag = vector_byte[`CBRS_VEC_MBE_BIT];
      next_st.working_bank_enable_flag = vector_byte[`CBRS_VEC_RBE_BIT];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // pointer, carry and registers keep no reset: undefined in hardware
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st <= next_st;
      st.stack_bank_select <= `CBRS_SBS_RESET;
      st.memory_bank_select <= `CBRS_SEL_RESET;
      st.register_bank_select <= 2'h0;
      st.sk <= 3'h0;
      st.ist <= 2'h0;
      st.data_bank_enable_flag <= 1'b0;
      st.working_bank_enable_flag <= 1'b0;
      st.push_wr <= 1'b0;
      st.mem_rdata <= 4'h0;
      st.mem_rdata8 <= 8'h00;
      st.push_addr <= 8'h00;
      st.push_data <= 8'h00;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign mem_rdata = st.mem_rdata;
  assign mem_rdata8 = st.mem_rdata8;
  assign reg_rdata = st.reg_rdata;
  assign pair_rdata = st.pair_rdata;
  // A is the low nibble of the wide pair, same order as pair access
  assign acc_a = st.regs[flat(bank_of(st.working_bank_enable_flag, st.register_bank_select), 3'h0)];
  assign acc_xa = {st.regs[flat(bank_of(st.working_bank_enable_flag, st.register_bank_select), 3'h1)],
                   st.regs[flat(bank_of(st.working_bank_enable_flag, st.register_bank_select), 3'h0)]};
  assign carry_bit = st.cy;
  assign processor_status_word = {st.cy, st.sk, st.ist, st.data_bank_enable_flag, st.working_bank_enable_flag};
  assign active_working_bank = bank_of(st.working_bank_enable_flag, st.register_bank_select);
  assign data_bank = (st.data_bank_enable_flag && st.memory_bank_select == `CBRS_BANK15) ? `CBRS_BANK15 : 4'h0;
  assign stack_top_pointer = st.sp;
  assign stack_push_addr = st.push_addr;
  assign stack_wdata = st.push_data;
  assign stack_wr = st.push_wr;
  assign extended_instruction_mode = ~st.stack_bank_select[`CBRS_SBS_MODE_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_push_predec: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_op == CBRS_ST_CALL |=> stack_push_addr == $past(st.sp) - 8'h01)
    else $error("push address not predecremented");
  chk_pop_postinc: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_op == CBRS_ST_RET && !mem_wr |=> st.sp == $past(st.sp) + 8'h01)
    else $error("pop did not increment pointer");
  chk_ist_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_op == CBRS_ST_INTR |=> st.ist == $past(st.ist) + 2'h1 && stack_wr)
    else $error("interrupt status not advanced");
  chk_bank_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.working_bank_enable_flag |-> active_working_bank == 2'h0)
    else $error("register bank not fixed to zero");
  chk_data_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.data_bank_enable_flag |-> data_bank == 4'h0)
    else $error("data bank not fixed to zero");
  chk_vector_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    vector_load |=> st.data_bank_enable_flag == $past(vector_byte[7]) && st.working_bank_enable_flag == $past(vector_byte[6]))
    else $error("enables not loaded from vector");
  chk_call_save: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_op == CBRS_ST_CALL |=> stack_wdata[7:2] == 6'h00)
    else $error("call saved more than enables");
  chk_sbs_reset: assert property (@(posedge core_clk)
    !rst_n |=> st.stack_bank_select == 4'h8 && extended_instruction_mode == 1'b0)
    else $error("stack selector reset wrong");
  cov_call: cover property (@(posedge core_clk) stack_op == CBRS_ST_CALL);
  cov_intr: cover property (@(posedge core_clk) stack_op == CBRS_ST_INTR);
  cov_return_from_interrupt: cover property (@(posedge core_clk) stack_op == CBRS_ST_RETURN_FROM_INTERRUPT);
endmodule // cbrs_core

// [core/cbrs_defs.svh]
/*
  Constants for the banked register state block: memory offsets, field positions,
  reset values and stack layout.
  Assumes inclusion by the register state module only.
*/
`ifndef CBRS_DEFS_SVH
`define CBRS_DEFS_SVH
// ----------------------------------------
// data memory offsets
// ----------------------------------------
`define CBRS_PSW_LO_ADDR 12'hFB0
`define CBRS_PSW_HI_ADDR 12'hFB1
`define CBRS_SP_ADDR 12'hF80
`define CBRS_SBS_ADDR 12'hF84
`define CBRS_BS_ADDR 12'hF86
`define CBRS_REG_TOP_ADDR 12'h01F
`define CBRS_STACK_TOP 8'h7F
// ----------------------------------------
// status word, vector byte and stack selector field positions
// ----------------------------------------
`define CBRS_PSW_CY 7
`define CBRS_PSW_SK2 6
`define CBRS_PSW_SK1 5
`define CBRS_PSW_SK0 4
`define CBRS_PSW_INTERRUPT_STATE_HIGH 3
`define CBRS_PSW_INTERRUPT_STATE_LOW 2
`define CBRS_PSW_MBE 1
`define CBRS_PSW_RBE 0
`define CBRS_VEC_MBE_BIT 7
`define CBRS_VEC_RBE_BIT 6
`define CBRS_SBS_MODE_BIT 3
// ----------------------------------------
// reset values and bank 15 number
// ----------------------------------------
`define CBRS_SBS_RESET 4'h8
`define CBRS_SEL_RESET 4'h0
`define CBRS_BANK15 4'hF
`endif

// [core/cbrs_pkg.sv]
/*
  Types for the banked register state block.
  Assumes the defines header sits beside it.
*/
package cbrs_pkg;
  typedef enum logic [3:0] {
    CBRS_OP_NONE, CBRS_OP_SET, CBRS_OP_CLR, CBRS_OP_NOT, CBRS_OP_LOAD,
    CBRS_OP_AND, CBRS_OP_OR, CBRS_OP_XOR, CBRS_OP_ARITH
  } cbrs_cy_op_t;
  typedef enum logic [2:0] {
    CBRS_ST_NONE, CBRS_ST_CALL, CBRS_ST_INTR, CBRS_ST_RET, CBRS_ST_RETURN_FROM_INTERRUPT,
    CBRS_ST_PUSHBS, CBRS_ST_POPBS
  } cbrs_stack_op_t;
  typedef enum logic [1:0] {
    CBRS_IST_ANY, CBRS_IST_HIGHER, CBRS_IST_NONE, CBRS_IST_BAD
  } cbrs_ist_t;
endpackage

// [sim/cbrs_stack_mem.sv]
/*
  Stack memory model beyond the register state block: 128 bytes of bank 0.
  Assumes pushes arrive on the registered stack_wr strobe.
*/
`timescale 1ns/10ps
module cbrs_stack_mem
(
  input wire logic core_clk,
  input wire logic stack_wr,
  input wire logic [7:0] stack_push_addr,
  input wire logic [7:0] stack_wdata,
  input wire logic [7:0] stack_top_pointer,
  output logic [7:0] stack_rdata
);
  // ------------------------------
  // storage
  // ------------------------------
  logic [7:0] mem [128];
  // seven address lines only, so a pointer of FF reads 7F
  assign stack_rdata = mem[stack_top_pointer[6:0]];
  always_ff @(posedge core_clk)
  begin
    if (stack_wr)
      mem[stack_push_addr[6:0]] <= stack_wdata;
  end
endmodule // cbrs_stack_mem

// [sim/test_cbrs_core.sv]
/*
  Self-checking bench for the banked register state block.
  Assumes inputs driven at the falling edge, one operation per cycle.
*/
`timescale 1ns/10ps
module test_cbrs_core;
  import cbrs_pkg::*;
  // ------------------------------
  // signals
  // ------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic vector_load, reg_wr, pair_wr, pair_alt, mem_wr, mem_rd, mem_wide, cy_in;
  logic skip_wr, mbe_bit_wr, rbe_bit_wr, flag_val, sel_mbs_wr, sel_rbs_wr, int_disabled;
  logic carry_bit, stack_wr, extended_instruction_mode, c;
  logic [1:0] pair_idx, sel_rbs, active_working_bank;
  logic [2:0] reg_idx, skip_in, s;
  logic [3:0] reg_wdata, mem_wdata, sel_mbs, mem_rdata, reg_rdata, acc_a, data_bank;
  logic [7:0] vector_byte, pair_wdata, mem_wdata8, stack_rdata, mem_rdata8, pair_rdata;
  logic [7:0] acc_xa, processor_status_word, stack_top_pointer, stack_push_addr;
  logic [7:0] stack_wdata, v, p;
  logic [11:0] mem_addr;
  logic [3:0] rf [32];
  cbrs_cy_op_t cy_op;
  cbrs_stack_op_t stack_op;
  cbrs_cy_op_t ops [8] = '{CBRS_OP_SET, CBRS_OP_CLR, CBRS_OP_NOT, CBRS_OP_LOAD,
    CBRS_OP_AND, CBRS_OP_OR, CBRS_OP_XOR, CBRS_OP_ARITH};
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 core_clk = ~core_clk;
  cbrs_core u_cbrs_core (.core_clk, .rst_n, .vector_byte, .vector_load, .reg_wr, .reg_idx,
    .reg_wdata, .pair_wr, .pair_idx, .pair_alt, .pair_wdata, .mem_wr, .mem_rd, .mem_addr,
    .mem_wdata, .mem_wide, .mem_wdata8, .cy_op, .cy_in, .skip_in, .skip_wr, .mbe_bit_wr,
    .rbe_bit_wr, .flag_val, .sel_mbs, .sel_mbs_wr, .sel_rbs, .sel_rbs_wr, .stack_op,
    .stack_rdata, .int_disabled, .mem_rdata, .mem_rdata8, .reg_rdata, .pair_rdata, .acc_a,
    .acc_xa, .carry_bit, .processor_status_word, .active_working_bank, .data_bank,
    .stack_top_pointer, .stack_push_addr, .stack_wdata, .stack_wr, .extended_instruction_mode);
  cbrs_stack_mem u_cbrs_stack_mem (.core_clk, .stack_wr, .stack_push_addr, .stack_wdata,
    .stack_top_pointer, .stack_rdata);
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic idle;
    {reg_wr, pair_wr, pair_alt, mem_wr, mem_rd, mem_wide, skip_wr} = '0;
    {mbe_bit_wr, rbe_bit_wr, sel_mbs_wr, sel_rbs_wr, vector_load} = '0;
    cy_op = CBRS_OP_NONE;
    stack_op = CBRS_ST_NONE;
  endtask
  task automatic step;
    @(negedge core_clk);
    idle();
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic mw(input logic [11:0] a, input logic [7:0] d, input logic w);
    mem_addr = a;
    mem_wdata = d[3:0];
    mem_wdata8 = d;
    mem_wide = w;
    mem_wr = 1'b1;
    step();
  endtask
  task automatic mr(input logic [11:0] a, input logic w);
    mem_addr = a;
    mem_wide = w;
    mem_rd = 1'b1;
    step();
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic cyx(cbrs_cy_op_t op, logic cc, logic i);
    case (op)
      CBRS_OP_SET: return 1'b1;
      CBRS_OP_CLR: return 1'b0;
      CBRS_OP_NOT: return ~cc;
      CBRS_OP_AND: return cc & i;
      CBRS_OP_OR: return cc | i;
      CBRS_OP_XOR: return cc ^ i;
      default: return i;
    endcase
  endfunction
  // a hang counts as a mismatch
  initial
  begin
    #400000;
    num_errors++;
    summarize();
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    void'($urandom(32'h7620012d));
    idle();
    {reg_idx, reg_wdata, pair_idx, pair_wdata, mem_addr, mem_wdata, mem_wdata8} = '0;
    {cy_in, skip_in, flag_val, sel_mbs, sel_rbs, int_disabled, vector_byte} = '0;
    repeat (12) @(negedge core_clk);
    chk("mode", extended_instruction_mode, 8'h00);
    chk("psw", processor_status_word[6:0], 8'h00);
    chk("bank", data_bank, 8'h00);
    rst_n = 1'b1;
    v = $urandom;
    vector_byte = v;
    vector_load = 1'b1;
    step();
    chk("enables", processor_status_word[1:0], v[7:6]);
    mr(`CBRS_SBS_ADDR, 1'b0);
    chk("sbs", mem_rdata, 8'h08);
    vector_byte = 8'h40;
    vector_load = 1'b1;
    step();
    for (int b = 0; b < 4; b++)
    begin
      sel_rbs = b[1:0];
      sel_rbs_wr = 1'b1;
      step();
      chk("awb", active_working_bank, b[7:0]);
      for (int q = 0; q < 4; q++)
      begin
        v = $urandom;
        {pair_idx, pair_wdata, pair_wr} = {q[1:0], v, 1'b1};
        step();
        {rf[b*8+2*q+1], rf[b*8+2*q]} = v;
      end
    end
    chk("acc_xa", acc_xa, {rf[25], rf[24]});
    chk("acc_a", acc_a, rf[24]);
    v = $urandom;
    {pair_idx, pair_wdata, pair_alt, pair_wr} = {2'd1, v, 2'b11};
    step();
    {rf[19], rf[18]} = v;
    pair_alt = 1'b1;
    step();
    chk("pair", pair_rdata, {rf[19], rf[18]});
    for (int i = 0; i < 8; i++)
    begin
      reg_idx = i[2:0];
      step();
      chk("reg", reg_rdata, rf[24+i]);
    end
    for (int i = 0; i < 32; i++)
    begin
      mr(i[11:0], 1'b0);
      chk("regmem", mem_rdata, rf[i]);
    end
    {rbe_bit_wr, flag_val} = 2'b10;
    step();
    chk("awb", active_working_bank, 8'h00);
    v = $urandom;
    mw(12'h000, v, 1'b0);
    chk("acc_a", acc_a, v[3:0]);
    {mbe_bit_wr, flag_val, sel_mbs, sel_mbs_wr} = 7'b1111111;
    step();
    chk("bank", data_bank, 8'h0F);
    {mbe_bit_wr, flag_val} = 2'b10;
    step();
    chk("bank", data_bank, 8'h00);
    mw(`CBRS_SP_ADDR, 8'h00, 1'b1);
    mr(`CBRS_SP_ADDR, 1'b1);
    chk("sp", mem_rdata8, 8'h00);
    mw(`CBRS_SBS_ADDR, 8'h00, 1'b0);
    chk("mode", extended_instruction_mode, 8'h01);
    {mbe_bit_wr, rbe_bit_wr, flag_val} = 3'b111;
    step();
    stack_op = CBRS_ST_CALL;
    step();
    chk("sp", stack_top_pointer, 8'hFF);
    chk("push_addr", stack_push_addr[6:0], 8'h7F);
    chk("push_data", stack_wdata, 8'h03);
    chk("push_wr", stack_wr, 8'h01);
    {mbe_bit_wr, rbe_bit_wr, flag_val} = 3'b110;
    step();
    chk("wr", stack_wr, 8'h00);
    stack_op = CBRS_ST_RET;
    step();
    chk("sp", stack_top_pointer, 8'h00);
    chk("enables", processor_status_word[1:0], 8'h03);
    int_disabled = 1'b1;
    mw(`CBRS_PSW_LO_ADDR, 8'h06, 1'b0);
    int_disabled = 1'b0;
    mw(`CBRS_PSW_LO_ADDR, 8'h09, 1'b0);
    mr(`CBRS_PSW_LO_ADDR, 1'b0);
    chk("psw_lo", mem_rdata, 8'h05);
    s = $urandom;
    skip_in = s;
    skip_wr = 1'b1;
    cy_op = CBRS_OP_SET;
    step();
    p = {1'b1, s, 4'h5};
    chk("psw", processor_status_word, p);
    stack_op = CBRS_ST_INTR;
    vector_byte = 8'h80;
    vector_load = 1'b1;
    step();
    chk("intr_data", stack_wdata, p);
    chk("psw_lo", processor_status_word[3:0], 8'h0A);
    cy_op = CBRS_OP_CLR;
    step();
    stack_op = CBRS_ST_RETURN_FROM_INTERRUPT;
    step();
    chk("psw", processor_status_word, p);
    mr(`CBRS_BS_ADDR, 1'b1);
    chk("bs", mem_rdata8, 8'hF3);
    stack_op = CBRS_ST_PUSHBS;
    step();
    chk("bs_data", stack_wdata, 8'hF3);
    {sel_mbs, sel_rbs, sel_mbs_wr, sel_rbs_wr} = 8'h03;
    step();
    stack_op = CBRS_ST_POPBS;
    step();
    mr(`CBRS_BS_ADDR, 1'b1);
    chk("bs", mem_rdata8, 8'hF3);
    mr(12'hF90, 1'b0);
    chk("unmapped", mem_rdata, 8'h00);
    c = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      cy_op = ops[i%8];
      cy_in = $urandom;
      c = cyx(cy_op, c, cy_in);
      step();
      chk("carry", carry_bit, c);
    end
    summarize();
  end
endmodule // test_cbrs_core
